// ===== testbench.sv
// Self-checking testbench for the watchdog counter block
`timescale 1ns/10ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin num_errors++; \
    $display("[ERR] %s exp %h got %h", nm, e, g); end end
module testbench;
    import watchdog_pkg::*;
    logic clock = 1'b0;
    logic reset_n = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, irq, rst_req, err;
    int num_errors = 0;
    int n_compared = 0;
    int n;
    watchdog_counter_control i_dut (.clock(clock), .reset_n(reset_n), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .interval_overflow_irq(irq),
        .internal_reset_request(rst_req));
    initial begin
        forever #5 clock = ~clock;
    end
    task automatic stop_test;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clock);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        do @(posedge clock); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // Keyed write to a protected register
    task automatic wk(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, {16'h0, write_key, d});
    endtask
    task automatic t_reset;
        apb(1'b0, control_offset, 32'h0);
        `CHK("ctl_reset", 8'h18, rd[7:0])
    endtask
    task automatic t_count_rw;
        // Slowest tap keeps the count still for this part
        wk(control_offset, 8'h27);
        wk(count_offset, 8'hab);
        apb(1'b1, count_offset, 32'h11);
        apb(1'b0, count_offset, 32'h0);
        `CHK("count_rw", 8'hab, rd[7:0])
        wk(control_offset, 8'h07);
        apb(1'b1, control_offset, 32'h20);
        apb(1'b0, count_offset, 32'h0);
        `CHK("count_stop", 8'h00, rd[7:0])
        apb(1'b0, control_offset, 32'h0);
        `CHK("ctl_nokey", 8'h1f, rd[7:0])
    endtask
    task automatic t_interval;
        apb(1'b1, irq_enable_offset, 32'h1);
        wk(control_offset, 8'h20);
        for (n = 0; n < 600 && irq !== 1'b1; n++) @(posedge clock);
        `CHK("irq", 1'b1, irq)
        apb(1'b0, control_offset, 32'h0);
        `CHK("ovf_set", 8'hb8, rd[7:0])
        // Polling software sees the flag twice before acting
        apb(1'b0, control_offset, 32'h0);
        `CHK("ovf_twice", 8'hb8, rd[7:0])
        wk(control_offset, 8'ha0);
        apb(1'b0, control_offset, 32'h0);
        `CHK("ovf_w1", 8'hb8, rd[7:0])
        wk(control_offset, 8'h20);
        apb(1'b0, control_offset, 32'h0);
        `CHK("ovf_clr", 8'h38, rd[7:0])
        apb(1'b1, irq_clear_offset, 32'h1);
        apb(1'b1, irq_enable_offset, 32'h0);
        // Registered output settles after the access edge
        @(negedge clock);
        `CHK("irq_clr", 1'b0, irq)
    endtask
    task automatic t_period;
        apb(1'b1, reset_action_offset, 32'h1);
        wk(control_offset, 8'h60);
        for (n = 0; n < 1200 && rst_req !== 1'b1; n++) @(posedge clock);
        n = 0;
        do begin
            @(posedge clock);
            n++;
        end while (rst_req !== 1'b1 && n < 1000);
        `CHK("period", 512, n)
        apb(1'b0, control_offset, 32'h0);
        `CHK("ovf_auto", 8'h78, rd[7:0])
    endtask
    task automatic t_unmapped;
        apb(1'b0, 8'h40, 32'h0);
        `CHK("unmapped", 1'b1, err)
    endtask
    initial begin
        repeat (8) @(posedge clock);
        reset_n <= 1'b1;
        t_reset();
        t_count_rw();
        t_interval();
        t_period();
        t_unmapped();
        stop_test();
    end
    initial begin
        #100us;
        num_errors++;
        stop_test();
    end
endmodule // testbench
bind watchdog_counter_control watchdog_monitor i_mon (.clock(clock), .reset_n(reset_n),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .interval_overflow_irq(interval_overflow_irq),
    .internal_reset_request(internal_reset_request));

// ===== watchdog_counter_control.sv
// Watchdog channel 0: counter, control/status register, APB slave, interrupt
`timescale 1ns/10ps
module watchdog_counter_control (
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic interval_overflow_irq,
    output logic internal_reset_request
);
    import watchdog_pkg::*;

    state_s state_r;
    state_s state_nxt;

    // ==========================================================
    // Helpers
    function automatic logic tap_hit(input logic [2:0] sel,
                                     input logic [prescale_width-1:0] pre);
        logic [prescale_width-1:0] mask;
        mask = '0;
        case (sel)
            3'h0: mask = 17'h00001;
            3'h1: mask = 17'h0003f;
            3'h2: mask = 17'h0007f;
            3'h3: mask = 17'h001ff;
            3'h4: mask = 17'h007ff;
            3'h5: mask = 17'h01fff;
            3'h6: mask = 17'h07fff;
            default: mask = 17'h1ffff;
        endcase
        tap_hit = (pre & mask) == mask;
    endfunction

    function automatic logic [7:0] control_image(input control_s c);
        control_image = {c.overflow_flag, c.timer_mode_select, c.timer_run_enable,
                         reserved_value, c.clock_select};
    endfunction

    // ==========================================================
    // Next state
    logic access;
    logic wr;
    logic rd;
    logic key_ok;
    logic tick;
    logic wrap;
    logic [7:0] wbyte;

    always_comb begin
        state_nxt = state_r;
        access = psel && penable;
        wr = access && pwrite;
        rd = access && !pwrite;
        key_ok = pwdata[key_lsb +: 8] == write_key;
        wbyte = pwdata[7:0];
        // Prescaler free runs; a divided rate is a one-cycle tick
        state_nxt.prescaler = state_r.prescaler + 1'b1;
        tick = state_r.ctrl.timer_run_enable
               && tap_hit(state_r.ctrl.clock_select, state_r.prescaler);
        wrap = tick && state_r.watchdog_count == 8'hff;
        state_nxt.reset_request = 1'b0;

        // Counting
        if (!state_r.ctrl.timer_run_enable) begin
            state_nxt.watchdog_count = count_reset;
        end else if (tick) begin
            state_nxt.watchdog_count = state_r.watchdog_count + 8'h01;
        end

        // Read while set arms the flag clear
        if (rd && paddr == control_offset && state_r.ctrl.overflow_flag) begin
            state_nxt.flag_seen = 1'b1;
        end

        // Register writes; count write beats a tick
        if (wr && key_ok) begin
            case (paddr)
                count_offset: begin
                    if (state_r.ctrl.timer_run_enable) begin
                        state_nxt.watchdog_count = wbyte;
                    end
                end
                control_offset: begin
                    state_nxt.ctrl.timer_mode_select = wbyte[mode_bit];
                    state_nxt.ctrl.timer_run_enable = wbyte[run_bit];
                    state_nxt.ctrl.clock_select = wbyte[2:0];
                    if (!wbyte[run_bit]) begin
                        state_nxt.watchdog_count = count_reset;
                    end
                    // Zero clears only after a read saw it set; one is ignored
                    if (!wbyte[overflow_bit] && state_r.flag_seen) begin
                        state_nxt.ctrl.overflow_flag = 1'b0;
                        state_nxt.flag_seen = 1'b0;
                    end
                end
                default: ;
            endcase
        end
        if (wr) begin
            case (paddr)
                irq_enable_offset: state_nxt.irq_enable = pwdata[1:0];
                irq_clear_offset: state_nxt.irq_status = state_r.irq_status & ~pwdata[1:0];
                reset_action_offset: state_nxt.reset_action = pwdata[0];
                default: ;
            endcase
        end

        // Overflow; set wins over any clear in the same cycle
        if (wrap) begin
            state_nxt.ctrl.overflow_flag = 1'b1;
            if (!state_r.ctrl.timer_mode_select) begin
                state_nxt.irq_status[irq_interval_bit] = 1'b1;
            end else begin
                state_nxt.irq_status[irq_wd_overflow_bit] = 1'b1;
                if (state_r.reset_action) begin
                    state_nxt.reset_request = 1'b1;
                    state_nxt.ctrl.overflow_flag = 1'b0;
                    state_nxt.flag_seen = 1'b0;
                end
            end
        end

        // Read data loaded in setup and held through the access edge
        if (psel && !penable) begin
            state_nxt.prdata = '0;
            if (!pwrite) begin
                case (paddr)
                    count_offset: state_nxt.prdata = {24'h0, state_r.watchdog_count};
                    control_offset: state_nxt.prdata = {24'h0, control_image(state_r.ctrl)};
                    irq_status_offset: state_nxt.prdata = {30'h0, state_r.irq_status};
                    irq_enable_offset: state_nxt.prdata = {30'h0, state_r.irq_enable};
                    reset_action_offset: state_nxt.prdata = {31'h0, state_r.reset_action};
                    default: state_nxt.prdata = '0;
                endcase
            end
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clock or negedge reset_n) begin
        if (!reset_n) begin
            state_r <= '0;
            state_r.watchdog_count <= count_reset;
            state_r.ctrl.clock_select <= clock_select_reset;
        end else begin
            state_r <= state_nxt;
        end
    end

    // ==========================================================
    // Outputs; setup-phase read keeps the slave at zero wait states
    assign prdata = state_r.prdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !(paddr == count_offset
        || paddr == control_offset || paddr == irq_status_offset
        || paddr == irq_enable_offset || paddr == irq_clear_offset
        || paddr == reset_action_offset);
    assign interval_overflow_irq = |(state_r.irq_status & state_r.irq_enable);
    assign internal_reset_request = state_r.reset_request;
endmodule // watchdog_counter_control

// ===== watchdog_monitor.sv
// Port checker for the watchdog counter block
`timescale 1ns/10ps
module watchdog_monitor
    import watchdog_pkg::*;
(
    input wire logic clock,
    input wire logic reset_n,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic interval_overflow_irq,
    input wire logic internal_reset_request
);
    // ==========================================================
    // Access phase helper
    logic acc;
    assign acc = psel && penable;
    default clocking dc @(posedge clock);
    endclocking
    default disable iff (!reset_n);
    chk_ready_high: assert property (acc |-> pready) else $error("pready low");
    chk_err_unmapped: assert property (acc && paddr > 8'h14 |-> pslverr)
        else $error("no error on unmapped");
    chk_err_mapped: assert property (acc && paddr <= 8'h14 && paddr[1:0] == 2'h0 |-> !pslverr)
        else $error("error on mapped");
    chk_reserved_ones: assert property (
        acc && !pwrite && paddr == control_offset |-> prdata[4:3] == reserved_value)
        else $error("reserved bits not one");
    chk_upper_zero: assert property (
        acc && !pwrite && paddr <= 8'h14 |-> prdata[31:8] == 24'h0)
        else $error("upper read bits set");
    chk_irq_masked: assert property (
        acc && pwrite && paddr == irq_enable_offset && pwdata[1:0] == 2'h0
        |=> !interval_overflow_irq) else $error("irq high while masked");
    // Overflow period is far longer than eight cycles
    chk_reset_spacing: assert property (
        $rose(internal_reset_request) |=> !internal_reset_request [*8])
        else $error("reset request not a single pulse");
    chk_stop_zero: assert property (
        acc && pwrite && paddr == control_offset && pwdata[15:8] == write_key
        && !pwdata[run_bit] ##[1:8] (acc && !pwrite && paddr == count_offset)
        |-> prdata[7:0] == 8'h00) else $error("count not zero when stopped");
endmodule // watchdog_monitor

// ===== watchdog_pkg.sv
// Package for the watchdog counter and its control/status register
//
// What this block does
// - An 8-bit up-counter advances on each selected prescaler tick; software can read it, and can write it only while the run enable is set.
// - Setting the run enable starts the counter; clearing it stops counting and forces the count to zero.
// - The overflow flag in control bit 7 sets whenever the count wraps from all ones to zero.
// - In watchdog mode with reset action selected, the resulting internal reset clears the overflow flag.
// - Writing a one to the overflow flag does nothing; only a zero write can clear it.
// - The overflow flag clears only after a read of the control register that saw it set, then a zero write.
// - Control bit 6 selects interval mode (0) or watchdog mode (1), and resets to interval mode.
// - Control bits 4 and 3 are reserved, always read as one and ignore writes.
// - The 3-bit clock select picks a tick of clock divided by 2, 64, 128, 512, 2048, 8192, 32768 or 131072.
// - The overflow period is 256 selected ticks, from zero counting up until the wrap.
// - The counter and control register accept writes only through a protected write method.
// - In interval mode every overflow raises the interval interrupt request.
// - In watchdog mode an overflow requests an internal reset when that action is selected, else no reset.
package watchdog_pkg;
    // ==========================================================
    // Register map (byte addresses)
    localparam logic [7:0] count_offset = 8'h00;
    localparam logic [7:0] control_offset = 8'h04;
    localparam logic [7:0] irq_status_offset = 8'h08;
    localparam logic [7:0] irq_enable_offset = 8'h0c;
    localparam logic [7:0] irq_clear_offset = 8'h10;
    localparam logic [7:0] reset_action_offset = 8'h14;
    // ==========================================================
    // Protected write key in pwdata[15:8]
    localparam logic [7:0] write_key = 8'h5a;
    localparam int key_lsb = 8;
    // ==========================================================
    // Control register fields
    localparam int overflow_bit = 7;
    localparam int mode_bit = 6;
    localparam int run_bit = 5;
    localparam logic [1:0] reserved_value = 2'h3;
    localparam logic [7:0] count_reset = 8'h00;
    localparam logic [2:0] clock_select_reset = 3'h0;
    // ==========================================================
    // Interrupt status layout
    localparam int irq_interval_bit = 0;
    localparam int irq_wd_overflow_bit = 1;
    // ==========================================================
    // Prescaler: longest tap is clock / 131072
    localparam int prescale_width = 17;

    typedef struct packed {
        logic overflow_flag;
        logic timer_mode_select;
        logic timer_run_enable;
        logic [2:0] clock_select;
    } control_s;

    typedef struct packed {
        logic [7:0] watchdog_count;
        control_s ctrl;
        logic flag_seen;
        logic [prescale_width-1:0] prescaler;
        logic [1:0] irq_status;
        logic [1:0] irq_enable;
        logic reset_action;
        logic reset_request;
        logic [31:0] prdata;
    } state_s;
endpackage
